// File: hw/ext_bus_pkg.sv
// package: shared constants, types and states for the external bus block
package ext_bus_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 16;
   // chip_config_byte field positions
   localparam int CFG_WIDTH_EN_BIT = 1;
   localparam int CFG_WAIT_LO_BIT = 4;
   localparam int CFG_WAIT_HI_BIT = 5;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [1:0] WAIT_RESET = 2'h0;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   typedef struct packed {
      logic write;
      logic internal;
      logic cfg_fetch;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_s;

   localparam int REQ_W = $bits(bus_req_s);

   typedef struct packed {
      logic wide;
      logic [DATA_W-1:0] rdata;
   } bus_rsp_s;

   // one-hot bus phases; ST_DATA and ST_WAIT last one bus_phase_clock period (2 clk), ST_ADDR and ST_DONE 1 clk
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_DATA = 5'h04,
      ST_WAIT = 5'h08,
      ST_DONE = 5'h10
   } bus_st_e;
endpackage

// File: hw/req_fifo.sv
// request fifo: parameterised width and depth, valid/ready both sides
`timescale 1ns/1ns
module req_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i, // core clock
   input wire logic rst_i, // async reset, active high
   input wire logic in_valid_i, // write request
   output logic in_ready_o, // not full
   input wire logic [WIDTH-1:0] in_data_i, // write word
   output logic out_valid_o, // not empty
   input wire logic out_ready_i, // consumer takes word
   output logic [WIDTH-1:0] out_data_o // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic push, pop;

   assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
   assign out_valid_o = wp_r != rp_r;
   assign out_data_o = mem[rp_r[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // storage has no reset; only pointers matter
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// File: hw/ext_bus_ctrl.sv
// external multiplexed bus controller with ready wait states
// Overview of operation
// - ready high means no added wait states
// - sample ready each falling phase edge; wait
// - ready high at falling edge ends waiting
// - stop waiting when count hits config limit
// - internal accesses ignore ready, never lengthened
// - waits active during config byte fetch
// - 8-bit cycles: upper pins address only
// - 16-bit cycles: upper pins address then data
// - lower pins always multiplex address and data
// - width input selects 16/8; disabled forces 8
// - address strobe only on external cycle start
// - read strobe low only for external reads
// - phase clock half input rate, 50% duty
`timescale 1ns/1ns
module ext_bus_ctrl
   import ext_bus_pkg::*;
(
   input wire logic clk_i, // core clock, 250 MHz
   input wire logic rst_i, // async reset, active high
   input wire logic [7:0] chip_config_byte_i, // configuration byte
   input wire logic req_valid_i, // bus request offered
   output logic req_ready_o, // request fifo has room
   input wire bus_req_s req_i, // request contents
   output logic rsp_valid_o, // one-cycle completion pulse
   output bus_rsp_s rsp_o, // read data and width used
   input wire logic ready_i, // ready pin, asynchronous
   input wire logic width_select_input_i, // width pin, asynchronous
   input wire logic [DATA_W-1:0] addr_data_pins_i, // pin input levels
   output logic [DATA_W-1:0] addr_data_pins_o, // pin drive values
   output logic [DATA_W-1:0] addr_data_pins_oe_n_o, // low = driving
   output logic address_valid_strobe_o, // high marks address phase
   output logic read_strobe_n_o, // low during external read
   output logic write_strobe_n_o, // low during external write
   output logic bus_phase_clock_o, // clk_i divided by two
   output logic busy_o // external cycle in progress
);
   bus_st_e st_r, st_nxt;
   bus_req_s cur_r, cur_nxt;
   bus_req_s head;
   logic head_valid, head_take;
   logic [1:0] rdy_sync_r, wid_sync_r;
   logic phase_r, wide_r, wide_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic [DATA_W-1:0] ad_o_nxt, oe_n_nxt, rdata_nxt;
   logic ale_nxt, rd_n_nxt, wr_n_nxt, busy_nxt, rsp_v_nxt;
   logic fall_edge, limit_hit;
   bus_rsp_s rsp_nxt;

   req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(req_valid_i),
      .in_ready_o(req_ready_o),
      .in_data_i(req_i),
      .out_valid_o(head_valid),
      .out_ready_i(head_take),
      .out_data_o(head)
   );

   // falling edge of phase clock happens when phase_r goes 1 -> 0
   assign fall_edge = phase_r;
   assign limit_hit = wait_r ==
      chip_config_byte_i[CFG_WAIT_HI_BIT:CFG_WAIT_LO_BIT];
   // new cycles only begin on a rising phase edge, keeping phases aligned
   assign head_take = (st_r == ST_IDLE) && head_valid && !phase_r;

   always_comb begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      wide_nxt = wide_r;
      wait_nxt = wait_r;
      ad_o_nxt = addr_data_pins_o;
      oe_n_nxt = '1;
      ale_nxt = 1'b0;
      rd_n_nxt = 1'b1;
      wr_n_nxt = 1'b1;
      busy_nxt = busy_o;
      rsp_v_nxt = 1'b0;
      rsp_nxt = rsp_o;
      rdata_nxt = rsp_o.rdata;
      case (st_r)
         ST_IDLE: begin
            busy_nxt = 1'b0;
            if (head_take) begin
               cur_nxt = head;
               wait_nxt = WAIT_RESET;
               if (head.internal) begin
                  // completes at once, ready never looked at
                  rsp_v_nxt = 1'b1;
                  rsp_nxt.wide = 1'b1;
                  rsp_nxt.rdata = '0;
               end else begin
                  st_nxt = ST_ADDR;
                  busy_nxt = 1'b1;
                  wide_nxt = chip_config_byte_i[CFG_WIDTH_EN_BIT]
                     && wid_sync_r[1] && !head.cfg_fetch;
                  ale_nxt = 1'b1;
                  ad_o_nxt = head.addr;
                  oe_n_nxt = '0;
               end
            end
         end
         ST_ADDR: begin
            ale_nxt = 1'b1;
            oe_n_nxt = '0;
            if (fall_edge) begin
               st_nxt = ST_DATA;
               ale_nxt = 1'b0;
               rd_n_nxt = cur_r.write;
               wr_n_nxt = !cur_r.write;
               if (cur_r.write) begin
                  ad_o_nxt[7:0] = cur_r.wdata[7:0];
                  if (wide_r) begin
                     ad_o_nxt[15:8] = cur_r.wdata[15:8];
                  end
               end else begin
                  oe_n_nxt[7:0] = '1;
                  // narrow read keeps upper address driven
                  oe_n_nxt[15:8] = {8{wide_r}};
               end
            end
         end
         ST_DATA, ST_WAIT: begin
            rd_n_nxt = read_strobe_n_o;
            wr_n_nxt = write_strobe_n_o;
            oe_n_nxt = addr_data_pins_oe_n_o;
            if (fall_edge) begin
               // ready sampled even during config fetch
               if (!rdy_sync_r[1] && !limit_hit) begin
                  st_nxt = ST_WAIT;
                  wait_nxt = wait_r + 2'h1;
               end else begin
                  st_nxt = ST_DONE;
                  rd_n_nxt = 1'b1;
                  wr_n_nxt = 1'b1;
                  rdata_nxt[7:0] = addr_data_pins_i[7:0];
                  rdata_nxt[15:8] = wide_r ? addr_data_pins_i[15:8] : 8'h00;
                  rsp_nxt.rdata = cur_r.write ? '0 : rdata_nxt;
                  rsp_nxt.wide = wide_r;
                  rsp_v_nxt = 1'b1;
                  oe_n_nxt = '0;
                  ad_o_nxt = cur_r.addr;
               end
            end
         end
         ST_DONE: begin
            oe_n_nxt = '0;
            st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE;
         cur_r <= '0;
         wide_r <= 1'b0;
         wait_r <= WAIT_RESET;
         phase_r <= 1'b0;
         rdy_sync_r <= SYNC_RESET;
         wid_sync_r <= SYNC_RESET;
         addr_data_pins_o <= '0;
         addr_data_pins_oe_n_o <= '1;
         address_valid_strobe_o <= 1'b0;
         read_strobe_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
         bus_phase_clock_o <= 1'b0;
         busy_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_o <= '0;
      end else begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         wide_r <= wide_nxt;
         wait_r <= wait_nxt;
         phase_r <= !phase_r;
         rdy_sync_r <= {rdy_sync_r[0], ready_i};
         wid_sync_r <= {wid_sync_r[0], width_select_input_i};
         addr_data_pins_o <= ad_o_nxt;
         addr_data_pins_oe_n_o <= oe_n_nxt;
         address_valid_strobe_o <= ale_nxt;
         read_strobe_n_o <= rd_n_nxt;
         write_strobe_n_o <= wr_n_nxt;
         bus_phase_clock_o <= !phase_r;
         busy_o <= busy_nxt;
         rsp_valid_o <= rsp_v_nxt;
         rsp_o <= rsp_nxt;
      end
   end

   // first edge after reset still sees the reset level on both sides
   a_phase_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |->
      bus_phase_clock_o != $past(bus_phase_clock_o))
      else $error("phase clock did not toggle");
   a_wait_limit: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r == ST_WAIT) |-> wait_r <=
      chip_config_byte_i[CFG_WAIT_HI_BIT:CFG_WAIT_LO_BIT])
      else $error("wait count beyond limit");
   a_ready_end: assert property (@(posedge clk_i) disable iff (rst_i)
      ((st_r == ST_DATA || st_r == ST_WAIT) && fall_edge && rdy_sync_r[1])
      |=> st_r == ST_DONE)
      else $error("ready high did not end cycle");
   a_ready_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      ((st_r == ST_DATA || st_r == ST_WAIT) && fall_edge && !rdy_sync_r[1]
      && !limit_hit) |=> st_r == ST_WAIT)
      else $error("ready low did not insert wait");
   a_internal_fast: assert property (@(posedge clk_i) disable iff (rst_i)
      (head_take && head.internal) |=> rsp_valid_o && !busy_o)
      else $error("internal access lengthened");
   a_strobe_ext: assert property (@(posedge clk_i) disable iff (rst_i)
      address_valid_strobe_o |-> busy_o)
      else $error("address strobe outside external cycle");
   a_read_ext: assert property (@(posedge clk_i) disable iff (rst_i)
      !read_strobe_n_o |-> busy_o && !cur_r.write)
      else $error("read strobe outside external read");
   a_narrow_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy_o && !wide_r) |-> addr_data_pins_oe_n_o[15:8] == 8'h00)
      else $error("upper pins released in narrow cycle");
   a_wait_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (head_take && !head.internal) |=> wait_r == 2'h0)
      else $error("wait counter not cleared");
   a_no_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r == ST_DATA && fall_edge && rdy_sync_r[1]) |=> ##2
      st_r == ST_IDLE)
      else $error("ready high cycle lengthened");
   c_waited: cover property (@(posedge clk_i) st_r == ST_WAIT);
   c_wide_read: cover property (@(posedge clk_i)
      rsp_valid_o && rsp_o.wide && !cur_r.write);
   c_fifo_full: cover property (@(posedge clk_i) !req_ready_o);
endmodule

// File: bench/ext_mem_model.sv
// partner model: external memory behind an address latch, slow ready
`timescale 1ns/1ns
module ext_mem_model (
   input wire logic clk_i, // core clock
   input wire logic rst_i, // async reset, active high
   input wire logic avs_i, // address valid strobe
   input wire logic rd_n_i, // read strobe, low active
   input wire logic wr_n_i, // write strobe, low active
   input wire logic [15:0] drv_i, // controller drive values
   input wire logic [15:0] oe_n_i, // controller enables, low = driving
   input wire logic [7:0] stall_i, // strobe cycles before ready, FF = never
   output logic [15:0] pins_o, // resolved pin levels
   output logic ready_o // ready pin
);
   logic [15:0] mem [16];
   logic [15:0] last_r;
   logic [15:0] own;
   logic [3:0] adr_r;
   logic [7:0] cnt_r;
   initial for (int i = 0; i < 16; i++) mem[i] = 16'hA5C3 ^ 16'(16'h1111 * i);
   // released lines show memory during a read, else the inverse of the last level
   assign own = (rd_n_i === 1'b0) ? mem[adr_r] : ~last_r;
   always_comb for (int b = 0; b < 16; b++) pins_o[b] = oe_n_i[b] ? own[b] : drv_i[b];
   assign ready_o = (stall_i != 8'hFF) && (cnt_r >= stall_i);
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_r <= 16'h0000;
         adr_r <= 4'h0;
         cnt_r <= 8'h00;
      end else begin
         last_r <= pins_o;
         if (avs_i) begin
            adr_r <= pins_o[3:0];
            cnt_r <= 8'h00;
         end else if (!rd_n_i || !wr_n_i) cnt_r <= cnt_r + 8'h01;
         // deselected: count clears so no stale count ends the next cycle
         else cnt_r <= 8'h00;
         if (!wr_n_i) mem[adr_r] <= pins_o;
      end
   end
endmodule

// File: bench/tb_external_bus_wait_state_mux.sv
// testbench: access sequences against the external bus controller
`timescale 1ns/1ns
module tb_external_bus_wait_state_mux;
   import ext_bus_pkg::*;
   logic clk_i, rst_i, req_valid_i, req_ready_o, rsp_valid_o, ready_i, wsel;
   logic avs, rd_n, wr_n, phc, phc_q, warm, busy;
   logic [7:0] cfg, stall;
   logic [15:0] pins_i, pins_o, oe_n;
   bus_req_s req;
   bus_rsp_s rsp_o;
   int err_count, num_checks, rd_len, wr_len, avs_n, busy_n, nrsp, up_rel, n;
   int base;
   ext_bus_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .chip_config_byte_i(cfg),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req),
      .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .ready_i(ready_i),
      .width_select_input_i(wsel), .addr_data_pins_i(pins_i),
      .addr_data_pins_o(pins_o), .addr_data_pins_oe_n_o(oe_n),
      .address_valid_strobe_o(avs), .read_strobe_n_o(rd_n),
      .write_strobe_n_o(wr_n), .bus_phase_clock_o(phc), .busy_o(busy));
   ext_mem_model m (.clk_i(clk_i), .rst_i(rst_i), .avs_i(avs), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .drv_i(pins_o), .oe_n_i(oe_n), .stall_i(stall),
      .pins_o(pins_i), .ready_o(ready_i));
   task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_rsp(input int target);
      int t;
      t = 0;
      while (nrsp < target) begin
         @(negedge clk_i);
         t++;
         if (t > 3000) begin
            err_count++;
            $display("[FAIL] response wait ran out");
            wrap_up();
         end
      end
   endtask
   task automatic acc(input logic w, input logic in, input logic cf,
         input logic [15:0] a, input logic [15:0] d);
      int k, t;
      k = nrsp;
      t = 0;
      @(negedge clk_i);
      {rd_len, wr_len, avs_n, busy_n, up_rel} = '0;
      req = '{w, in, cf, a, d};
      req_valid_i = 1'b1;
      // ready seen at a falling edge means the next rising edge takes it
      while (req_ready_o !== 1'b1 && t < 100) begin
         @(negedge clk_i);
         t++;
      end
      if (t >= 100) begin
         err_count++;
         $display("[FAIL] request never accepted");
         wrap_up();
      end
      @(negedge clk_i);
      req_valid_i = 1'b0;
      wait_rsp(k + 1);
      repeat (3) @(negedge clk_i);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (!rst_i && warm) chk("phase clock", {16'h0, ~phc_q}, {16'h0, phc});
      phc_q <= phc;
      warm <= !rst_i;
      if (!rst_i) begin
         rd_len += (rd_n === 1'b0);
         wr_len += (wr_n === 1'b0);
         busy_n += (busy === 1'b1);
         nrsp += (rsp_valid_o === 1'b1);
         avs_n += (avs === 1'b1);
         up_rel += (rd_n === 1'b0 && oe_n[15:8] !== 8'h00);
      end
   end
   initial begin
      {rst_i, req_valid_i, wsel, cfg, stall, req} = {1'b1, 1'b0, 1'b1, 8'h02, 8'h00, REQ_W'(0)};
      {err_count, num_checks, nrsp} = '0;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      acc(1'b0, 1'b0, 1'b0, 16'h1235, 16'h0000);
      chk("wide read", {1'b1, m.mem[5]}, rsp_o);
      chk("read strobe", 17'h2, 17'(rd_len));
      chk("upper released", 17'h2, 17'(up_rel));
      chk("address strobes", 17'h1, 17'(avs_n));
      acc(1'b1, 1'b0, 1'b0, 16'h4326, 16'hBEEF);
      chk("wide write", {1'b0, 16'hBEEF}, {1'b0, m.mem[6]});
      chk("no read strobe", 17'h0, 17'(rd_len));
      chk("write strobe", 17'h2, 17'(wr_len));
      for (int s = 0; s < 2; s++) begin
         {wsel, cfg} = s ? {1'b1, 8'h00} : {1'b0, 8'h02};
         acc(1'b0, 1'b0, 1'b0, 16'h9A75, 16'h0000);
         chk("narrow read", {9'h0, m.mem[5][7:0]}, rsp_o);
         chk("upper kept", 17'h0, 17'(up_rel));
      end
      {wsel, stall} = {1'b1, 8'hFF};
      // back to back limits prove the count clears per cycle
      for (int l = 0; l < 4; l++) begin
         cfg = {2'b00, 2'(l), 4'h2};
         acc(1'b0, 1'b0, 1'b0, 16'h0003, 16'h0000);
         chk("wait limit", 17'(2 + 2 * l), 17'(rd_len));
      end
      stall = 8'h03;
      acc(1'b0, 1'b0, 1'b0, 16'h0003, 16'h0000);
      chk("early end", 17'h6, 17'(rd_len));
      {stall, cfg} = {8'hFF, 8'h22};
      acc(1'b0, 1'b0, 1'b1, 16'h2018, 16'h0000);
      chk("fetch waits", 17'h6, 17'(rd_len));
      chk("fetch narrow", {9'h0, m.mem[8][7:0]}, rsp_o);
      acc(1'b0, 1'b1, 1'b0, 16'h0003, 16'h0000);
      chk("internal", 17'h0, 17'(rd_len + busy_n + avs_n));
      chk("internal data", 17'h10000, rsp_o);
      cfg = 8'h32;
      n = 0;
      // some of the burst completes while it is still being offered
      base = nrsp;
      @(negedge clk_i);
      req = '{1'b0, 1'b0, 1'b0, 16'h0001, 16'h0000};
      req_valid_i = 1'b1;
      for (int i = 0; i < 24; i++) begin
         n += (req_ready_o === 1'b1);
         @(negedge clk_i);
      end
      req_valid_i = 1'b0;
      chk("fifo refused", 17'h1, 17'(n >= 16 && n < 24));
      wait_rsp(base + n);
      chk("fifo drained", 17'h1, {16'h0, req_ready_o});
      wrap_up();
   end
endmodule
